// *** design/gpmx_pkg.sv ***
// Purpose: shared constants, types and helpers of the signal routing matrix
// Assumes: one clock; text commands arrive one byte per strobe
// Notes: source codes are five bits wide; unlisted codes never get stored
package gpmx_pkg;

    // source selector codes
    localparam logic [4:0] CODE_LOW = 5'h00;
    localparam logic [4:0] CODE_HIGH = 5'h01;
    localparam logic [4:0] CODE_FTW = 5'h03;
    localparam logic [4:0] CODE_FACT = 5'h04;
    localparam logic [4:0] CODE_EXPA = 5'h05;
    localparam logic [4:0] CODE_FVAL = 5'h06;
    localparam logic [4:0] CODE_LVAL = 5'h07;
    localparam logic [4:0] CODE_PG0 = 5'h08;
    localparam logic [4:0] CODE_PG1 = 5'h09;
    localparam logic [4:0] CODE_PG2 = 5'h0a;
    localparam logic [4:0] CODE_PG3 = 5'h0b;
    localparam logic [4:0] CODE_TTLIN1 = 5'h0c;
    localparam logic [4:0] CODE_CC1 = 5'h0d;
    localparam logic [4:0] CODE_GATE0 = 5'h0e;
    localparam logic [4:0] CODE_GATE1 = 5'h0f;
    localparam logic [4:0] CODE_TTLIN2 = 5'h10;
    localparam logic [4:0] CODE_LVDS = 5'h11;
    localparam logic [7:0] CODE_MAX = 8'h1f;

    // packed command names, right aligned, zero filled on the left
    localparam logic [55:0] NAME_TTL_SRC0 = 56'h00000000_4c5330;
    localparam logic [55:0] NAME_TTL_SRC1 = 56'h00000000_4c5331;
    localparam logic [55:0] NAME_TTL_SRC2 = 56'h00000000_4c5332;
    localparam logic [55:0] NAME_TTL_INV0 = 56'h00000000_4c4930;
    localparam logic [55:0] NAME_TTL_INV1 = 56'h00000000_4c4931;
    localparam logic [55:0] NAME_TTL_INV2 = 56'h00000000_4c4932;
    localparam logic [55:0] NAME_G0_SRC1 = 56'h00_4e4430494e31;
    localparam logic [55:0] NAME_G0_SRC2 = 56'h00_4e4430494e32;
    localparam logic [55:0] NAME_G1_SRC1 = 56'h00_4e4431494e31;
    localparam logic [55:0] NAME_G1_SRC2 = 56'h00_4e4431494e32;
    localparam logic [55:0] NAME_G0_INV1 = 56'h4e4430494e5631;
    localparam logic [55:0] NAME_G0_INV2 = 56'h4e4430494e5632;
    localparam logic [55:0] NAME_G1_INV1 = 56'h4e4431494e5631;
    localparam logic [55:0] NAME_G1_INV2 = 56'h4e4431494e5632;
    localparam logic [2:0] NAME_MAX = 3'h7;

    // command indices
    localparam logic [3:0] CMD_TTL_SRC = 4'h0;  // 0..2
    localparam logic [3:0] CMD_TTL_INV = 4'h3;  // 3..5
    localparam logic [3:0] CMD_G0_SRC = 4'h6;   // 6..7
    localparam logic [3:0] CMD_G1_SRC = 4'h8;   // 8..9
    localparam logic [3:0] CMD_G0_INV = 4'ha;   // 10..11
    localparam logic [3:0] CMD_G1_INV = 4'hc;   // 12..13
    localparam logic [3:0] CMD_NONE = 4'hf;

    // ascii characters
    localparam logic [7:0] ASC_CR = 8'h0d;
    localparam logic [7:0] ASC_LF = 8'h0a;
    localparam logic [7:0] ASC_EQ = 8'h3d;
    localparam logic [7:0] ASC_QM = 8'h3f;
    localparam logic [7:0] ASC_ZERO = 8'h30;
    localparam logic [7:0] ASC_NINE = 8'h39;
    localparam logic [7:0] ASC_O = 8'h4f;
    localparam logic [7:0] ASC_K = 8'h4b;
    localparam logic [7:0] ASC_N = 8'h4e;
    localparam logic [7:0] ASC_G = 8'h47;
    localparam logic [7:0] VAL_SAT = 8'h18;     // above this a further digit may overflow
    localparam logic [7:0] TEN = 8'h0a;
    localparam logic [2:0] REP_LONG = 3'h4;
    localparam logic [2:0] REP_SHORT = 3'h3;

    typedef enum logic [1:0] {gpmx_kind_out, gpmx_kind_g0, gpmx_kind_g1} gpmx_kind_t;

    // signals offered to the selectors
    typedef struct packed {
        logic frame_trigger_wait_a;
        logic frame_active_b;
        logic exposure_active_c;
        logic frame_valid;
        logic line_valid;
        logic [3:0] pulse_gen;
        logic ttl_input_1;
        logic camera_control_line1_input;
        logic ttl_input_2;
        logic lvds_input;
    } gpmx_src_t;

    // all settings; the all-zero value is the reset default
    typedef struct packed {
        logic [2:0][4:0] ttl_src;
        logic [2:0] ttl_inv;
        logic [1:0][4:0] g0_src;
        logic [1:0] g0_inv;
        logic [1:0][4:0] g1_src;
        logic [1:0] g1_inv;
    } gpmx_cfg_t;
    localparam gpmx_cfg_t CFG_RESET = '0;

    // true when a code belongs to the encoding of the given selector kind
    function automatic logic code_ok(input logic [4:0] code, input gpmx_kind_t kind);
        case (code)
            CODE_LOW, CODE_HIGH, CODE_FTW, CODE_FACT, CODE_EXPA, CODE_FVAL,
            CODE_PG0, CODE_PG1, CODE_PG2, CODE_PG3, CODE_TTLIN1, CODE_CC1,
            CODE_TTLIN2, CODE_LVDS: code_ok = 1'b1;
            CODE_LVAL: code_ok = (kind == gpmx_kind_g1);
            CODE_GATE0: code_ok = (kind != gpmx_kind_g0);
            CODE_GATE1: code_ok = (kind != gpmx_kind_g1);
            default: code_ok = 1'b0;
        endcase
    endfunction : code_ok

endpackage : gpmx_pkg

// *** design/gpmx_src_sel.sv ***
// Purpose: one source selector with optional polarity inversion
// Assumes: code already checked against its encoding when written
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
module gpmx_src_sel
    import gpmx_pkg::*;
(
    input wire logic [4:0] code_in,
    input wire gpmx_src_t src_in,
    input wire logic gate0_in,
    input wire logic gate1_in,
    input wire logic invert_in,
    output logic sel_out
);
    logic raw;

    // code to signal decode, shared by every selector
    always_comb begin
        case (code_in)
            CODE_HIGH: raw = 1'b1;
            CODE_FTW: raw = src_in.frame_trigger_wait_a;
            CODE_FACT: raw = src_in.frame_active_b;
            CODE_EXPA: raw = src_in.exposure_active_c;
            CODE_FVAL: raw = src_in.frame_valid;
            CODE_LVAL: raw = src_in.line_valid;
            CODE_PG0: raw = src_in.pulse_gen[0];
            CODE_PG1: raw = src_in.pulse_gen[1];
            CODE_PG2: raw = src_in.pulse_gen[2];
            CODE_PG3: raw = src_in.pulse_gen[3];
            CODE_TTLIN1: raw = src_in.ttl_input_1;
            CODE_CC1: raw = src_in.camera_control_line1_input;
            CODE_GATE0: raw = gate0_in;
            CODE_GATE1: raw = gate1_in;
            CODE_TTLIN2: raw = src_in.ttl_input_2;
            CODE_LVDS: raw = src_in.lvds_input;
            default: raw = 1'b0;  // low, and any unlisted code
        endcase
    end

    // inversion applied after selection
    assign sel_out = raw ^ invert_in;
endmodule : gpmx_src_sel

// *** design/gpmx_routing_matrix.sv ***
// Purpose: routing matrix for three ttl outputs and two feedback nand gates
// Assumes: settings arrive as short text commands NAME=value or NAME? ended by cr lf
// Notes: gate outputs are registered, so feedback between gates never forms a loop
// Summary of operation
// (R1) Each input of the second gate has its own invert setting, 0 passes and 1 inverts.
// (R2) The first ttl output selects low, high, trigger wait, frame active, exposure or fval.
// (R3) It also selects pulse generators 0-3, ttl in 1, cc1, both gates, ttl in 2 and lvds.
// (R4) The second and third ttl outputs have own selectors with the same encoding.
// (R5) The first input of the first gate uses the output encoding without its own gate.
// (R6) The second input of the first gate has its own selector with that code set.
// (R7) The first input of the second gate adds line valid and omits its own gate.
// (R8) The second input of the second gate has its own selector with that code set.
// (R9) Each input of the first gate has its own invert setting, default off.
// (R10) Each ttl output has an invert applied after its selector, default off.
// (R11) Each gate outputs the nand of its two selected and optionally inverted inputs.
// (R12) A write of a code outside a selector's encoding is refused and the old value kept.
`timescale 1ns/1ps
module gpmx_routing_matrix
    import gpmx_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic char_valid_in,
    input wire logic [7:0] char_data_in,
    input wire gpmx_src_t src_in,
    output logic [2:0] ttl_out,
    output logic gate0_out,
    output logic gate1_out,
    output logic reply_valid_out,
    output logic [7:0] reply_data_out
);
    typedef enum logic [1:0] {gpmx_st_name, gpmx_st_value, gpmx_st_query, gpmx_st_lf} gpmx_state_t;

    gpmx_state_t state_q;
    logic [55:0] name_q;
    logic [2:0] name_len_q;
    logic [7:0] value_q;
    logic val_seen_q;
    logic query_q;
    logic err_q;
    gpmx_cfg_t cfg_q;
    logic [2:0] ttl_q;
    logic gate0_q;
    logic gate1_q;
    logic [7:0] rep_buf_q [0:3];
    logic [2:0] rep_cnt_q;
    logic [1:0] rep_pos_q;
    logic rep_valid_q;
    logic [7:0] rep_data_q;

    logic [2:0] ttl_sel;
    logic [1:0] g0_sel;
    logic [1:0] g1_sel;
    logic is_digit;
    logic exec;
    logic [3:0] cmd;
    logic write_ok;
    logic query_ok;
    logic [4:0] rd_val;
    logic [7:0] rd_ones;

    // command name to index
    function automatic logic [3:0] cmd_decode(input logic [55:0] name);
        case (name)
            NAME_TTL_SRC0: cmd_decode = CMD_TTL_SRC;
            NAME_TTL_SRC1: cmd_decode = CMD_TTL_SRC + 4'h1;
            NAME_TTL_SRC2: cmd_decode = CMD_TTL_SRC + 4'h2;
            NAME_TTL_INV0: cmd_decode = CMD_TTL_INV;
            NAME_TTL_INV1: cmd_decode = CMD_TTL_INV + 4'h1;
            NAME_TTL_INV2: cmd_decode = CMD_TTL_INV + 4'h2;
            NAME_G0_SRC1: cmd_decode = CMD_G0_SRC;
            NAME_G0_SRC2: cmd_decode = CMD_G0_SRC + 4'h1;
            NAME_G1_SRC1: cmd_decode = CMD_G1_SRC;
            NAME_G1_SRC2: cmd_decode = CMD_G1_SRC + 4'h1;
            NAME_G0_INV1: cmd_decode = CMD_G0_INV;
            NAME_G0_INV2: cmd_decode = CMD_G0_INV + 4'h1;
            NAME_G1_INV1: cmd_decode = CMD_G1_INV;
            NAME_G1_INV2: cmd_decode = CMD_G1_INV + 4'h1;
            default: cmd_decode = CMD_NONE;
        endcase
    endfunction : cmd_decode

    // legality of a written value for a command
    function automatic logic value_ok(input logic [3:0] c, input logic [7:0] v);
        if (c < CMD_TTL_INV) begin
            value_ok = (v <= CODE_MAX) && code_ok(v[4:0], gpmx_kind_out);  // R12
        end else if (c < CMD_G0_SRC) begin
            value_ok = (v <= 8'h01);
        end else if (c < CMD_G1_SRC) begin
            value_ok = (v <= CODE_MAX) && code_ok(v[4:0], gpmx_kind_g0);  // R5 R6 R12
        end else if (c < CMD_G0_INV) begin
            value_ok = (v <= CODE_MAX) && code_ok(v[4:0], gpmx_kind_g1);  // R7 R8 R12
        end else begin
            value_ok = (v <= 8'h01) && (c != CMD_NONE);
        end
    endfunction : value_ok

    // current value of a setting, for queries
    function automatic logic [4:0] rd_field(input gpmx_cfg_t c, input logic [3:0] i);
        case (i)
            4'h0, 4'h1, 4'h2: rd_field = c.ttl_src[2'(i)];
            4'h3, 4'h4, 4'h5: rd_field = {4'h0, c.ttl_inv[2'(i - CMD_TTL_INV)]};
            4'h6, 4'h7: rd_field = c.g0_src[i[0]];
            4'h8, 4'h9: rd_field = c.g1_src[i[0]];
            4'ha, 4'hb: rd_field = {4'h0, c.g0_inv[i[0]]};
            4'hc, 4'hd: rd_field = {4'h0, c.g1_inv[i[0]]};
            default: rd_field = 5'h00;
        endcase
    endfunction : rd_field

    // ttl output selectors, inversion applied after selection
    for (genvar k = 0; k < 3; k++) begin : g_ttl
        gpmx_src_sel u_sel (
            .code_in(cfg_q.ttl_src[k]),
            .src_in(src_in),
            .gate0_in(gate0_q),
            .gate1_in(gate1_q),
            .invert_in(cfg_q.ttl_inv[k]),
            .sel_out(ttl_sel[k])
        );  // R2 R3 R4 R10
    end

    // gate input selectors with per-input inversion
    for (genvar k = 0; k < 2; k++) begin : g_gate
        gpmx_src_sel u_g0 (
            .code_in(cfg_q.g0_src[k]),
            .src_in(src_in),
            .gate0_in(gate0_q),
            .gate1_in(gate1_q),
            .invert_in(cfg_q.g0_inv[k]),
            .sel_out(g0_sel[k])
        );  // R5 R6 R9
        gpmx_src_sel u_g1 (
            .code_in(cfg_q.g1_src[k]),
            .src_in(src_in),
            .gate0_in(gate0_q),
            .gate1_in(gate1_q),
            .invert_in(cfg_q.g1_inv[k]),
            .sel_out(g1_sel[k])
        );  // R1 R7 R8
    end

    // registered outputs and gates
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ttl_q <= 3'h0;
            gate0_q <= 1'b1;
            gate1_q <= 1'b1;
        end else begin
            ttl_q <= ttl_sel;
            gate0_q <= ~(g0_sel[0] & g0_sel[1]);  // R11
            gate1_q <= ~(g1_sel[0] & g1_sel[1]);  // R11
        end
    end

    assign is_digit = (char_data_in >= ASC_ZERO) && (char_data_in <= ASC_NINE);
    assign exec = char_valid_in && (state_q == gpmx_st_lf) && (char_data_in == ASC_LF);
    assign cmd = cmd_decode(name_q);
    assign query_ok = exec && query_q && !err_q && (cmd != CMD_NONE);
    assign write_ok = exec && !query_q && !err_q && val_seen_q && value_ok(cmd, value_q);
    assign rd_val = rd_field(cfg_q, cmd);
    assign rd_ones = (rd_val >= TEN[4:0]) ? ({3'h0, rd_val} - TEN) : {3'h0, rd_val};

    // text command parser
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= gpmx_st_name;
            name_q <= '0;
            name_len_q <= 3'h0;
            value_q <= 8'h00;
            val_seen_q <= 1'b0;
            query_q <= 1'b0;
            err_q <= 1'b0;
        end else if (char_valid_in) begin
            if (state_q == gpmx_st_lf) begin
                // lf executes; anything else drops the command
                state_q <= gpmx_st_name;
                name_q <= '0;
                name_len_q <= 3'h0;
                value_q <= 8'h00;
                val_seen_q <= 1'b0;
                query_q <= 1'b0;
                err_q <= 1'b0;
            end else if (char_data_in == ASC_CR) begin
                state_q <= gpmx_st_lf;
                if (state_q == gpmx_st_name) begin
                    err_q <= 1'b1;  // no separator seen
                end
            end else begin
                case (state_q)
                    gpmx_st_name: begin
                        if (char_data_in == ASC_EQ) begin
                            state_q <= gpmx_st_value;
                        end else if (char_data_in == ASC_QM) begin
                            state_q <= gpmx_st_query;
                            query_q <= 1'b1;
                        end else if (name_len_q == NAME_MAX) begin
                            err_q <= 1'b1;
                        end else begin
                            name_q <= {name_q[47:0], char_data_in};
                            name_len_q <= name_len_q + 3'h1;
                        end
                    end
                    gpmx_st_value: begin
                        if (!is_digit || value_q > VAL_SAT) begin
                            err_q <= 1'b1;
                        end else begin
                            value_q <= 8'(value_q * TEN + (char_data_in - ASC_ZERO));
                            val_seen_q <= 1'b1;
                        end
                    end
                    default: err_q <= 1'b1;  // text after '?'
                endcase
            end
        end
    end

    // settings store; refused writes leave everything as it was
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg_q <= CFG_RESET;
        end else if (write_ok) begin  // R12
            if (cmd < CMD_TTL_INV) begin
                cfg_q.ttl_src[2'(cmd)] <= value_q[4:0];  // R2 R3 R4
            end else if (cmd < CMD_G0_SRC) begin
                cfg_q.ttl_inv[2'(cmd - CMD_TTL_INV)] <= value_q[0];  // R10
            end else if (cmd < CMD_G1_SRC) begin
                cfg_q.g0_src[cmd[0]] <= value_q[4:0];  // R5 R6
            end else if (cmd < CMD_G0_INV) begin
                cfg_q.g1_src[cmd[0]] <= value_q[4:0];  // R7 R8
            end else if (cmd < CMD_G1_INV) begin
                cfg_q.g0_inv[cmd[0]] <= value_q[0];  // R9
            end else begin
                cfg_q.g1_inv[cmd[0]] <= value_q[0];  // R1
            end
        end
    end

    // reply buffer: value for a query, ok for a write, ng otherwise
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < 4; i++) begin
                rep_buf_q[i] <= 8'h00;
            end
            rep_cnt_q <= 3'h0;
            rep_pos_q <= 2'h0;
        end else if (exec) begin
            rep_pos_q <= 2'h0;
            if (query_ok && rd_val >= TEN[4:0]) begin
                rep_buf_q[0] <= ASC_ZERO + 8'h01;
                rep_buf_q[1] <= ASC_ZERO + rd_ones;
                rep_buf_q[2] <= ASC_CR;
                rep_buf_q[3] <= ASC_LF;
                rep_cnt_q <= REP_LONG;
            end else if (query_ok) begin
                rep_buf_q[0] <= ASC_ZERO + rd_ones;
                rep_buf_q[1] <= ASC_CR;
                rep_buf_q[2] <= ASC_LF;
                rep_buf_q[3] <= 8'h00;
                rep_cnt_q <= REP_SHORT;
            end else begin
                rep_buf_q[0] <= write_ok ? ASC_O : ASC_N;
                rep_buf_q[1] <= write_ok ? ASC_K : ASC_G;
                rep_buf_q[2] <= ASC_CR;
                rep_buf_q[3] <= ASC_LF;
                rep_cnt_q <= REP_LONG;
            end
        end else if (rep_cnt_q != 3'h0) begin
            rep_cnt_q <= rep_cnt_q - 3'h1;
            rep_pos_q <= rep_pos_q + 2'h1;
        end
    end

    // reply byte stream, one byte per cycle
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rep_valid_q <= 1'b0;
            rep_data_q <= 8'h00;
        end else begin
            rep_valid_q <= (rep_cnt_q != 3'h0) && !exec;
            rep_data_q <= (rep_cnt_q != 3'h0 && !exec) ? rep_buf_q[rep_pos_q] : 8'h00;
        end
    end

    assign ttl_out = ttl_q;
    assign gate0_out = gate0_q;
    assign gate1_out = gate1_q;
    assign reply_valid_out = rep_valid_q;
    assign reply_data_out = rep_data_q;

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    chk_ttl1_high: assert property ( // R2
        (cfg_q.ttl_src[0] == CODE_HIGH && !cfg_q.ttl_inv[0] && !write_ok) |=> ttl_q[0])
        else $error("ttl output 1 not high for high source");
    chk_ttl2_pulse: assert property ( // R3 R4
        (cfg_q.ttl_src[1] == CODE_PG2 && !cfg_q.ttl_inv[1] && !write_ok)
        |=> ttl_q[1] == $past(src_in.pulse_gen[2]))
        else $error("ttl output 2 does not follow pulse generator 2");
    chk_ttl3_invert: assert property ( // R10
        (cfg_q.ttl_src[2] == CODE_LOW && cfg_q.ttl_inv[2] && !write_ok) |=> ttl_q[2])
        else $error("inverted low source not high on ttl output 3");
    chk_gate0_nand: assert property ( // R5 R6 R11
        (cfg_q.g0_src == {CODE_HIGH, CODE_HIGH} && cfg_q.g0_inv == 2'h0 && !write_ok)
        |=> !gate0_q)
        else $error("first gate not low with both inputs high");
    chk_gate0_invert: assert property ( // R9
        (cfg_q.g0_src == {CODE_LOW, CODE_HIGH} && cfg_q.g0_inv == 2'h2 && !write_ok)
        |=> !gate0_q)
        else $error("first gate input inversion not applied");
    chk_gate1_lval: assert property ( // R7 R8
        (cfg_q.g1_src == {CODE_HIGH, CODE_LVAL} && cfg_q.g1_inv == 2'h0 && !write_ok)
        |=> gate1_q == !$past(src_in.line_valid))
        else $error("second gate does not follow line valid");
    chk_gate1_invert: assert property ( // R1
        (cfg_q.g1_src == {CODE_LOW, CODE_LOW} && cfg_q.g1_inv == 2'h3 && !write_ok)
        |=> !gate1_q)
        else $error("second gate input inversion not applied");
    chk_reject_keep: assert property ( // R12
        (exec && !write_ok) |=> cfg_q == $past(cfg_q))
        else $error("refused command changed a setting");
    chk_codes_legal: assert property ( // R12
        code_ok(cfg_q.ttl_src[0], gpmx_kind_out) && code_ok(cfg_q.g0_src[1], gpmx_kind_g0)
        && code_ok(cfg_q.g1_src[0], gpmx_kind_g1))
        else $error("unlisted code held in a selector");
    chk_reply_burst: assert property (
        exec |=> rep_cnt_q != 3'h0 ##1 reply_valid_out [*3])
        else $error("reply burst not sent after command");

    cov_write: cover property (write_ok);
    cov_query: cover property (query_ok);
    cov_refuse: cover property (exec && !query_q && !write_ok);
    cov_feedback: cover property (cfg_q.g1_src[0] == CODE_GATE0 && !gate1_q);
endmodule : gpmx_routing_matrix

// *** tb/gpmx_ext_equip.sv ***
// Purpose: external trigger and strobe equipment feeding the selectable signals
// Assumes: levels change just after the rising edge, by one fixed small delay
// Notes: hold_in freezes the levels so that routed values can be compared
`timescale 1ns/1ps
module gpmx_ext_equip
    import gpmx_pkg::*;
(
    input wire logic clk_in,
    input wire logic hold_in,
    output gpmx_src_t src_out
);
    // fresh random levels on every edge unless frozen
    initial begin
        src_out = '0;
        forever begin
            @(posedge clk_in);
            if (!hold_in) begin
                src_out <= #1 $bits(gpmx_src_t)'($urandom);
            end
        end
    end
endmodule : gpmx_ext_equip

// *** tb/test_gpio_signal_routing_matrix.sv ***
// Purpose: self-checking bench of the signal routing matrix
// Assumes: replies arrive within a few cycles of the line feed
// Notes: expectations come from the bench's own selector model
`timescale 1ns/1ps
module test_gpio_signal_routing_matrix;
    import gpmx_pkg::*;
    logic clk_in = 0, sys_rst_in = 1, char_valid_in = 0, hold = 1, g0, g1;
    logic [7:0] char_data_in = '0;
    gpmx_src_t src;
    logic [2:0] ttl_out;
    logic gate0_out, gate1_out, reply_valid_out;
    logic [7:0] reply_data_out;
    int bad_count = 0, total_checks = 0, cfg[14];
    logic [55:0] nm[14] = '{NAME_TTL_SRC0, NAME_TTL_SRC1, NAME_TTL_SRC2, NAME_TTL_INV0,
        NAME_TTL_INV1, NAME_TTL_INV2, NAME_G0_SRC1, NAME_G0_SRC2, NAME_G1_SRC1, NAME_G1_SRC2,
        NAME_G0_INV1, NAME_G0_INV2, NAME_G1_INV1, NAME_G1_INV2};
    // hand-picked gate settings for commands 6..13: nand, invert, feedback
    int corner[3][8] = '{'{1, 1, 7, 1, 0, 0, 0, 0}, '{1, 0, 0, 0, 0, 1, 1, 1},
        '{0, 1, 14, 1, 0, 0, 0, 0}};
    gpmx_routing_matrix gpmx_routing_matrix_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .char_valid_in(char_valid_in), .char_data_in(char_data_in), .src_in(src),
        .ttl_out(ttl_out), .gate0_out(gate0_out), .gate1_out(gate1_out),
        .reply_valid_out(reply_valid_out), .reply_data_out(reply_data_out));
    gpmx_ext_equip gpmx_ext_equip_i (.clk_in(clk_in), .hold_in(hold), .src_out(src));
    // free running clock
    initial begin
        forever #25 clk_in = ~clk_in;
    end
    // expected level of a selector for a code
    function automatic logic sel(logic [4:0] c, gpmx_src_t s, logic a, logic b);
        case (c)
            5'h01: return 1'b1;
            5'h03: return s.frame_trigger_wait_a;
            5'h04: return s.frame_active_b;
            5'h05: return s.exposure_active_c;
            5'h06: return s.frame_valid;
            5'h07: return s.line_valid;
            5'h08, 5'h09, 5'h0a, 5'h0b: return s.pulse_gen[c[1:0]];
            5'h0c: return s.ttl_input_1;
            5'h0d: return s.camera_control_line1_input;
            5'h0e: return a;
            5'h0f: return b;
            5'h10: return s.ttl_input_2;
            5'h11: return s.lvds_input;
            default: return 1'b0;
        endcase
    endfunction : sel
    // expected nand of gate inputs i and i+1, inverts at i+4 and i+5
    function automatic logic nd(int i, gpmx_src_t s, logic a, logic b);
        return !((sel(5'(cfg[i]), s, a, b) ^ cfg[i + 4][0]) & (sel(5'(cfg[i + 1]), s, a, b)
            ^ cfg[i + 5][0]));
    endfunction : nd
    // code accepted by kind 0 ttl, 1 first gate, 2 second gate
    function automatic bit lg(int c, int k);
        return c <= 17 && c != 2 && !(c == 7 && k != 2) && !(c == 14 && k == 1)
            && !(c == 15 && k == 2);
    endfunction : lg
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one command byte
    task automatic put(input logic [7:0] b);
        @(posedge clk_in);
        #1;
        char_valid_in = 1'b1;
        char_data_in = b;
    endtask : put
    // whole command, then collect the reply burst
    task automatic xfer(input int i, input int v, input bit q, output logic [31:0] r);
        r = '0;
        for (int j = 6; j >= 0; j--) begin
            if (nm[i][j*8+:8] != 8'h00) begin
                put(nm[i][j*8+:8]);
            end
        end
        put(q ? ASC_QM : ASC_EQ);
        if (!q && v > 9) begin
            put(8'(48 + v / 10));
        end
        if (!q) begin
            put(8'(48 + v % 10));
        end
        put(ASC_CR);
        put(ASC_LF);
        @(posedge clk_in);
        #1;
        char_valid_in = 1'b0;
        for (int n = 0; n < 12; n++) begin
            @(posedge clk_in);
            #2;
            if (reply_valid_out === 1'b1) begin
                r = {r[23:0], reply_data_out};
            end else if (r != 0) begin
                break;
            end
        end
    endtask : xfer
    // write a setting; unlisted values must be refused
    task automatic wr(input int i, input int v);
        logic [31:0] r;
        bit ok;
        ok = (i inside {[3:5], [10:13]}) ? v <= 1 : lg(v, i < 6 ? 0 : i < 8 ? 1 : 2);
        xfer(i, v, 1'b0, r);
        chk(r, ok ? 32'h4f4b0d0a : 32'h4e470d0a);
        if (ok) begin
            cfg[i] = v;
        end
    endtask : wr
    // read a setting back in decimal
    task automatic qry(input int i);
        logic [31:0] r;
        logic [31:0] e;
        e = cfg[i] > 9 ? {8'(48 + cfg[i] / 10), 8'(48 + cfg[i] % 10), 16'h0d0a} :
            {8'h00, 8'(48 + cfg[i]), 16'h0d0a};
        xfer(i, 0, 1'b1, r);
        chk(r, e);
    endtask : qry
    // new source levels, then let gates and lines settle
    task automatic stim();
        @(posedge clk_in);
        #1;
        hold = 1'b0;
        @(posedge clk_in);
        #1;
        hold = 1'b1;
        repeat (4) @(posedge clk_in);
        #2;
    endtask : stim
    // verdict and end of run
    task automatic conclude();
        if (bad_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    // watchdog
    initial begin
        #(30000 * 50);
        bad_count++;
        conclude();
    end
    // main sequence
    initial begin
        void'($urandom(32'hcc24));
        repeat (12) @(posedge clk_in);
        #1;
        sys_rst_in = 1'b0;
        @(posedge clk_in);
        #2;
        chk(ttl_out, 0);
        chk({gate0_out, gate1_out}, 2'b11);
        for (int i = 0; i < 14; i++) begin
            cfg[i] = 0;
            qry(i);
        end
        for (int k = 0; k < 3; k++) begin
            for (int c = 0; c < 32; c++) begin
                wr(k, c);
                wr(k + 3, c % 3);
                stim();
                chk(ttl_out[k], sel(5'(cfg[k]), src, 1'b1, 1'b1) ^ cfg[k + 3][0]);
            end
            qry(k);
            wr(k + 3, 0);
        end
        wr(2, 0);
        wr(5, 1);
        stim();
        chk(ttl_out[2], 1'b1);
        wr(0, 14);
        wr(1, 15);
        for (int t = 0; t < 24; t++) begin
            for (int i = 6; i < 14; i++) begin
                int v;
                v = i < 10 ? $urandom_range(31, 0) : $urandom_range(2, 0);
                if (t < 3) begin
                    v = corner[t][i - 6];
                end
                wr(i, v);
            end
            if (cfg[6] == 15 || cfg[7] == 15) begin
                for (int i = 8; i < 10; i++) begin
                    if (cfg[i] == 14) begin
                        wr(i, 7); // keeps the two gates out of a feedback loop
                    end
                end
            end
            stim();
            g0 = nd(6, src, 1'b0, 1'b0);
            g1 = nd(8, src, g0, 1'b0);
            g0 = nd(6, src, 1'b0, g1);
            chk(gate1_out, g1);
            chk(gate0_out, g0);
            chk(ttl_out[1:0], {g1, g0});
        end
        conclude();
    end
endmodule : test_gpio_signal_routing_matrix
